// File: design/ser_core.sv
// status byte, event flags and message buffers of the instrument
//
// What this block does
// (RULE1) response buffer of 128 bytes, emptied when read
// (RULE2) flush output on power-on, query error, clear, switch
// (RULE3) command input buffer of 128 bytes
// (RULE4) interface switch discards buffers, clears status
// (RULE5) 8-bit status byte presented for serial poll
// (RULE6) enabled bit rising sets summary, raises request
// (RULE7) status query does not clear summary bit
// (RULE8) bit 5 set by masked event flags
// (RULE9) bit 4 set while a response is queued
// (RULE10) request enable mask gates summary and request
// (RULE11) event flags clear on clear, read, power, switch
// (RULE12) event enable mask gates event summary
// (RULE13) power-on flag set on power-up and switch
// (RULE14) event bits 6 and 1 never set
// (RULE15) command error sets event bit 5
// (RULE16) execution error sets event bit 4
// (RULE17) device error sets event bit 3
// (RULE18) query error sets bit 2, empties output
// (RULE19) operation complete sets event bit 0
// (RULE20) status and flags read only, masks read/write
// (RULE21) unused status bits read zero, never request
// (RULE22) query error means no response sent
`timescale 1ns/1ps
`include "ser_params.svh"
module ser_core
	import ser_pkg::*;
(
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_nrst,
	// interface events
	input  wire logic       i_if_switch,
	input  wire logic       i_dev_clear,
	input  wire logic       i_prog_start,
	input  wire logic       i_poll,
	// incoming program bytes
	input  wire logic       i_in_valid,
	input  wire logic [7:0] i_in_byte,
	output logic            o_in_ready,
	// program bytes to the parser
	output logic            o_cmd_valid,
	output logic [7:0]      o_cmd_byte,
	input  wire logic       i_cmd_ready,
	// common commands and error events
	input  wire ser_cmd_t   i_cmd,
	input  wire ser_evt_t   i_evt,
	output logic            o_reg_valid,
	output logic [7:0]      o_reg_data,
	// response bytes from the formatter
	input  wire logic       i_rsp_valid,
	input  wire logic [7:0] i_rsp_byte,
	input  wire logic       i_rsp_end,
	input  wire logic       i_rsp_abort,
	output logic            o_rsp_ready,
	// response bytes to the host
	output logic            o_out_valid,
	output logic [7:0]      o_out_byte,
	output logic            o_out_last,
	input  wire logic       i_out_ready,
	input  wire logic       i_out_read_req,
	// serial poll status
	output logic [7:0]      o_status_byte,
	output logic            o_srq
);
	function automatic logic [`SER_PTR_W-1:0] ser_fill(
		input logic [`SER_PTR_W-1:0] wr,
		input logic [`SER_PTR_W-1:0] rd);
		ser_fill = wr - rd;
	endfunction : ser_fill

	// input buffer
	logic [7:0]            in_mem_q [`SER_BUF_DEPTH];
	logic [`SER_PTR_W-1:0] in_wr_q, in_wr_d, in_rd_q, in_rd_d;
	logic                  in_push, in_pop;

	// output buffer
	logic [8:0]            out_mem_q [`SER_BUF_DEPTH];
	logic [`SER_PTR_W-1:0] ow_q, ow_d, oc_q, oc_d, or_q, or_d;
	logic [`SER_PTR_W-1:0] msgs_q, msgs_d;
	logic                  out_push, out_pop, out_flush, read_empty;
	logic                  qye_set;

	// status registers
	logic [7:0]            evt_q, evt_d, ese_q, ese_d, sre_q, sre_d;
	logic [7:0]            stb_q, stb_d, evt_set;
	logic [1:0]            src_prev_q, src_en;
	logic                  srq_q, srq_d, event_summary_bit, message_available_bit, master_summary_bit, rise;
	logic                  rv_q, rv_d;
	logic [7:0]            rd_q, rd_d;

	// (RULE3) input storage
	assign o_in_ready  = ser_fill(in_wr_q, in_rd_q) != 8'h80;
	assign o_cmd_valid = in_wr_q != in_rd_q;
	assign o_cmd_byte  = in_mem_q[in_rd_q[`SER_IDX_W-1:0]];
	assign in_push     = i_in_valid && o_in_ready;
	assign in_pop      = o_cmd_valid && i_cmd_ready;

	always_comb begin
		in_wr_d = in_wr_q + (in_push ? 8'h01 : 8'h00);
		in_rd_d = in_rd_q + (in_pop ? 8'h01 : 8'h00);
		// (RULE4) switch discards input
		if (i_if_switch || i_dev_clear) begin
			in_wr_d = 8'h00;
			in_rd_d = 8'h00;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			in_wr_q <= 8'h00;
			in_rd_q <= 8'h00;
		end else begin
			in_wr_q <= in_wr_d;
			in_rd_q <= in_rd_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (in_push)
			in_mem_q[in_wr_q[`SER_IDX_W-1:0]] <= i_in_byte;
	end

	// (RULE1) output storage
	assign o_rsp_ready = ser_fill(ow_q, or_q) != 8'h80;
	assign o_out_valid = oc_q != or_q;
	assign o_out_byte  = out_mem_q[or_q[`SER_IDX_W-1:0]][7:0];
	assign o_out_last  = out_mem_q[or_q[`SER_IDX_W-1:0]][8];
	assign out_push    = i_rsp_valid && o_rsp_ready && !i_rsp_abort;
	assign out_pop     = o_out_valid && i_out_ready;
	// (RULE18) query error sources
	assign read_empty  = i_out_read_req && !o_out_valid;
	assign qye_set     = i_evt.qry_err || read_empty ||
		(i_prog_start && (ow_q != or_q));
	// (RULE2) flush sources
	assign out_flush   = qye_set || i_dev_clear || i_if_switch;

	always_comb begin
		ow_d   = ow_q + (out_push ? 8'h01 : 8'h00);
		oc_d   = oc_q;
		or_d   = or_q + (out_pop ? 8'h01 : 8'h00);
		msgs_d = msgs_q;
		if (out_push && i_rsp_end) begin
			oc_d = ow_d;
			msgs_d = msgs_d + 8'h01;
		end
		if (out_pop && o_out_last)
			msgs_d = msgs_d - 8'h01;
		// (RULE22) errored reply dropped
		if (i_rsp_abort)
			ow_d = oc_q;
		// (RULE2) empty output buffer
		if (out_flush) begin
			ow_d   = 8'h00;
			oc_d   = 8'h00;
			or_d   = 8'h00;
			msgs_d = 8'h00;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ow_q   <= 8'h00;
			oc_q   <= 8'h00;
			or_q   <= 8'h00;
			msgs_q <= 8'h00;
		end else begin
			ow_q   <= ow_d;
			oc_q   <= oc_d;
			or_q   <= or_d;
			msgs_q <= msgs_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (out_push)
			out_mem_q[ow_q[`SER_IDX_W-1:0]] <= {i_rsp_end, i_rsp_byte};
	end

	// event flag sources
	always_comb begin
		evt_set = 8'h00;
		// (RULE13) power-on flag
		evt_set[`SER_BIT_PON] = i_if_switch;
		// (RULE15) command error
		evt_set[`SER_BIT_CME] = i_evt.cmd_err;
		// (RULE16) execution error
		evt_set[`SER_BIT_EXE] = i_evt.exe_err;
		// (RULE17) device error
		evt_set[`SER_BIT_DDE] = i_evt.dev_err;
		// (RULE18) query error
		evt_set[`SER_BIT_QYE] = qye_set;
		// (RULE19) operation complete
		evt_set[`SER_BIT_OPC] = i_evt.opc_done;
	end

	// (RULE12) masked event summary
	assign event_summary_bit    = |(evt_q & ese_q);
	// (RULE9) queued message present
	assign message_available_bit    = msgs_q != 8'h00;
	// (RULE10) request mask gating
	assign src_en = {event_summary_bit, message_available_bit} & sre_q[`SER_BIT_ESB:`SER_BIT_MAV];
	assign master_summary_bit    = |src_en;
	assign rise   = |(src_en & ~src_prev_q);

	always_comb begin
		evt_d = evt_q;
		ese_d = ese_q;
		sre_d = sre_q;
		srq_d = srq_q;
		rv_d  = 1'b0;
		rd_d  = rd_q;
		// (RULE20) command access
		unique case (i_cmd.op)
			SER_OP_CLS: evt_d = 8'h00;
			SER_OP_ESE_SET: ese_d = i_cmd.data;
			SER_OP_SRE_SET: sre_d = i_cmd.data;
			SER_OP_ESE_QRY: begin
				rv_d = 1'b1;
				rd_d = ese_q;
			end
			SER_OP_SRE_QRY: begin
				rv_d = 1'b1;
				rd_d = sre_q;
			end
			// (RULE7) query keeps summary
			SER_OP_STB_QRY: begin
				rv_d = 1'b1;
				rd_d = stb_q;
			end
			// (RULE11) read then clear
			SER_OP_ESR_QRY: begin
				rv_d  = 1'b1;
				rd_d  = evt_q;
				evt_d = 8'h00;
			end
			default: ;
		endcase
		// (RULE4) switch clears status
		if (i_if_switch) begin
			evt_d = 8'h00;
			ese_d = `SER_MASK_RST;
			sre_d = `SER_MASK_RST;
			srq_d = 1'b0;
		end
		// (RULE14) unused flags stay zero
		evt_d = (evt_d | evt_set) & 8'hBD;
		if (i_poll)
			srq_d = 1'b0;
		// (RULE6) request on rising bit
		if (rise)
			srq_d = 1'b1;
		// (RULE21) undefined bits zero
		stb_d = 8'h00;
		stb_d[`SER_BIT_MSS] = master_summary_bit;
		// (RULE8) event summary bit
		stb_d[`SER_BIT_ESB] = event_summary_bit;
		stb_d[`SER_BIT_MAV] = message_available_bit;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			// (RULE13) power-up flag
			evt_q      <= `SER_EVT_RST;
			ese_q      <= `SER_MASK_RST;
			sre_q      <= `SER_MASK_RST;
			stb_q      <= 8'h00;
			src_prev_q <= 2'b00;
			srq_q      <= 1'b0;
			rv_q       <= 1'b0;
			rd_q       <= 8'h00;
		end else begin
			evt_q      <= evt_d;
			ese_q      <= ese_d;
			sre_q      <= sre_d;
			stb_q      <= stb_d;
			src_prev_q <= src_en;
			srq_q      <= srq_d;
			rv_q       <= rv_d;
			rd_q       <= rd_d;
		end
	end

	// (RULE5) poll status outputs
	assign o_status_byte = stb_q;
	assign o_srq         = srq_q;
	assign o_reg_valid   = rv_q;
	assign o_reg_data    = rd_q;

	sequence ser_rise_s;
		rise && !i_if_switch;
	endsequence
	sequence ser_srq_s;
		o_srq && o_status_byte[`SER_BIT_MSS];
	endsequence

	flush_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE2
		i_dev_clear |=> !o_out_valid)
		else $error("output not flushed on device clear");
	mav_track_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE9
		##1 o_status_byte[`SER_BIT_MAV] == ($past(msgs_q) != 8'h00))
		else $error("message available bit wrong");
	pon_switch_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE13
		i_if_switch |=> evt_q[`SER_BIT_PON] && o_cmd_valid == 1'b0)
		else $error("switch did not set power-on flag");
	unused_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE21
		(o_status_byte & 8'h8F) == 8'h00 && (evt_q & 8'h42) == 8'h00)
		else $error("unused bit set");
	esr_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE11
		i_cmd.op == SER_OP_ESR_QRY && evt_set == 8'h00
		|=> evt_q == 8'h00 && o_reg_valid && o_reg_data == $past(evt_q))
		else $error("event read did not clear flags");
	srq_rise_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE6
		ser_rise_s |=> ser_srq_s)
		else $error("no service request on rising bit");
	cme_set_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE15
		i_evt.cmd_err |=> evt_q[`SER_BIT_CME])
		else $error("command error not flagged");
	qye_flush_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE18
		read_empty |=> evt_q[`SER_BIT_QYE] && msgs_q == 8'h00)
		else $error("query error not flagged");
	abort_quiet_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RULE22
		i_rsp_abort && !o_out_valid && !i_rsp_valid |=> !o_out_valid)
		else $error("aborted reply became visible");
endmodule : ser_core

// File: shared/ser_params.svh
// constants for the status and event reporting block
`ifndef SER_PARAMS_SVH
`define SER_PARAMS_SVH
`define SER_BUF_DEPTH     128
`define SER_PTR_W         8
`define SER_IDX_W         7
`define SER_EVT_RST       8'h80
`define SER_MASK_RST      8'h00
`define SER_BIT_MSS       6
`define SER_BIT_ESB       5
`define SER_BIT_MAV       4
`define SER_BIT_PON       7
`define SER_BIT_URQ       6
`define SER_BIT_CME       5
`define SER_BIT_EXE       4
`define SER_BIT_DDE       3
`define SER_BIT_QYE       2
`define SER_BIT_RQC       1
`define SER_BIT_OPC       0
`define SER_SRE_USED      8'h30
`endif

// File: shared/ser_pkg.sv
// types for the status and event reporting block
package ser_pkg;
	typedef enum logic [3:0] {
		SER_OP_NONE    = 4'h0,
		SER_OP_CLS     = 4'h1,
		SER_OP_ESE_SET = 4'h2,
		SER_OP_ESE_QRY = 4'h3,
		SER_OP_ESR_QRY = 4'h4,
		SER_OP_SRE_SET = 4'h5,
		SER_OP_SRE_QRY = 4'h6,
		SER_OP_STB_QRY = 4'h7
	} ser_op_t;

	typedef struct packed {
		ser_op_t    op;
		logic [7:0] data;
	} ser_cmd_t;

	typedef struct packed {
		logic cmd_err;
		logic exe_err;
		logic dev_err;
		logic qry_err;
		logic opc_done;
	} ser_evt_t;
endpackage : ser_pkg

// File: verification/ser_host_model.sv
// host side model that drains the response buffer
`timescale 1ns/1ps
module ser_host_model (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	// response stream
	input  wire logic i_out_valid,
	input  wire logic i_stall,
	output logic      o_out_ready
);
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_out_ready <= 1'b0;
		end else begin
			o_out_ready <= i_out_valid && !i_stall;
		end
	end
endmodule : ser_host_model

// File: verification/ser_core_test.sv
// self-checking bench for the status and event block
`timescale 1ns/1ps
module ser_core_test;
	import ser_pkg::*;
	logic        clk, nrst, sw, dclr, pst, poll, in_v, c_rdy, stall;
	logic        r_v, r_end, r_ab, rd_req, o_rdy;
	logic [7:0]  in_b, r_b, d;
	ser_cmd_t    cmd;
	ser_evt_t    evt;
	logic        in_rdy, cv, rv, rs_rdy, ov, ol, srq;
	logic [7:0]  cb, rd, ob, stb;
	logic [31:0] seed;
	logic [8:0]  rq[$], oq[$], iq[$];
	int          fail_count, tests_run, n;
	logic [7:0]  ev_exp [5] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20};

	ser_core i_ser_core (.i_core_clk(clk), .i_nrst(nrst), .i_if_switch(sw),
		.i_dev_clear(dclr), .i_prog_start(pst), .i_poll(poll),
		.i_in_valid(in_v), .i_in_byte(in_b), .o_in_ready(in_rdy),
		.o_cmd_valid(cv), .o_cmd_byte(cb), .i_cmd_ready(c_rdy),
		.i_cmd(cmd), .i_evt(evt), .o_reg_valid(rv), .o_reg_data(rd),
		.i_rsp_valid(r_v), .i_rsp_byte(r_b), .i_rsp_end(r_end),
		.i_rsp_abort(r_ab), .o_rsp_ready(rs_rdy), .o_out_valid(ov),
		.o_out_byte(ob), .o_out_last(ol), .i_out_ready(o_rdy),
		.i_out_read_req(rd_req), .o_status_byte(stb), .o_srq(srq));
	ser_host_model i_ser_host_model (.i_core_clk(clk), .i_nrst(nrst),
		.i_out_valid(ov), .i_stall(stall), .o_out_ready(o_rdy));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	task automatic op(input ser_op_t o, input logic [7:0] v);
		cmd = '{o, v};
		@(negedge clk);
		cmd = '{SER_OP_NONE, 8'h00};
		@(negedge clk);
	endtask : op

	task automatic q(input ser_op_t o, input logic [7:0] v);
		rq.push_back({1'b0, v});
		op(o, v);
	endtask : q

	task automatic ev(input ser_evt_t e);
		evt = e;
		@(negedge clk);
		evt = '0;
		@(negedge clk);
	endtask : ev

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask : pulse

	task automatic rsp(input logic [7:0] b, input logic e);
		{r_v, r_b, r_end} = {1'b1, b, e};
		@(negedge clk);
		{r_v, r_end} = 2'b00;
		@(negedge clk);
	endtask : rsp

	// results leave the queues in order
	always @(posedge clk) begin
		if (rv === 1'b1)
			chk({1'b0, rd}, rq.size() ? rq.pop_front() : 9'h1FF);
		if (ov === 1'b1 && o_rdy === 1'b1)
			chk({ol, ob}, oq.size() ? oq.pop_front() : 9'h1FF);
		if (cv === 1'b1 && c_rdy === 1'b1)
			chk({1'b0, cb}, iq.size() ? iq.pop_front() : 9'h1FF);
	end

	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end

	initial begin
		{sw, dclr, pst, poll, in_v, c_rdy, r_v, r_end, r_ab, rd_req} = '0;
		{in_b, r_b, evt, stall, nrst} = '0;
		cmd = '{SER_OP_NONE, 8'h00};
		{seed, fail_count, tests_run} = {32'd56500, 64'd0};
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		stall = 1'b1;
		q(SER_OP_ESR_QRY, 8'h80);
		q(SER_OP_ESR_QRY, 8'h00);
		repeat (4) begin
			d = rnd();
			op(SER_OP_ESE_SET, d);
			q(SER_OP_ESE_QRY, d);
			op(SER_OP_SRE_SET, ~d);
			q(SER_OP_SRE_QRY, ~d);
		end
		for (int i = 0; i < 5; i++) begin
			ev(ser_evt_t'(5'h01 << i));
			q(SER_OP_ESR_QRY, ev_exp[i]);
		end
		ev('1);
		q(SER_OP_ESR_QRY, 8'h3D);
		op(SER_OP_ESE_SET, 8'h20);
		op(SER_OP_SRE_SET, 8'h20);
		pulse(poll);
		ev(ser_evt_t'(5'h10));
		@(negedge clk);
		chk({srq, stb}, 9'h160);
		q(SER_OP_STB_QRY, 8'h60);
		q(SER_OP_STB_QRY, 8'h60);
		pulse(poll);
		op(SER_OP_SRE_SET, 8'h00);
		@(negedge clk);
		chk({srq, stb}, 9'h020);
		op(SER_OP_CLS, 8'h00);
		@(negedge clk);
		chk({srq, stb}, 9'h000);
		rsp(8'hA5, 1'b0);
		pulse(r_ab);
		for (int i = 0; i < 3; i++) begin
			d = rnd();
			oq.push_back({i == 2, d});
			rsp(d, i == 2);
		end
		chk({srq, stb}, 9'h010);
		for (int i = 0; i < 300 && oq.size() > 0; i++) begin
			d = rnd();
			stall = d[0];
			@(negedge clk);
		end
		stall = 1'b1;
		repeat (2) @(negedge clk);
		chk({srq, stb}, 9'h000);
		rsp(8'h3C, 1'b1);
		pulse(dclr);
		chk({ov, stb}, 9'h000);
		rsp(8'hC3, 1'b1);
		pulse(pst);
		chk({ov, stb}, 9'h000);
		pulse(rd_req);
		stall = 1'b0;
		repeat (4) @(negedge clk);
		q(SER_OP_ESR_QRY, 8'h04);
		n = 0;
		{in_v, r_v} = 2'b11;
		while (in_rdy === 1'b1 && n < 200) begin
			{in_b, r_b} = {n[7:0], n[7:0]};
			iq.push_back({1'b0, n[7:0]});
			n++;
			@(negedge clk);
		end
		{in_v, r_v} = 2'b00;
		chk(n[8:0], 9'd128);
		chk({7'h00, in_rdy, rs_rdy}, 9'h000);
		pulse(r_ab);
		chk({8'h00, rs_rdy}, 9'h001);
		for (int i = 0; i < 600 && iq.size() > 0; i++) begin
			d = rnd();
			c_rdy = d[1];
			@(negedge clk);
		end
		{c_rdy, stall} = 2'b01;
		op(SER_OP_ESE_SET, 8'hFF);
		op(SER_OP_SRE_SET, 8'hFF);
		{in_v, in_b} = {1'b1, 8'h5A};
		@(negedge clk);
		in_v = 1'b0;
		rsp(8'h77, 1'b1);
		pulse(sw);
		chk({cv, ov, srq}, 9'h000);
		q(SER_OP_ESR_QRY, 8'h80);
		q(SER_OP_ESE_QRY, 8'h00);
		q(SER_OP_SRE_QRY, 8'h00);
		stall = 1'b0;
		repeat (4) @(negedge clk);
		chk(9'(rq.size() + oq.size() + iq.size()), 9'h000);
		give_verdict();
	end
endmodule : ser_core_test
